// File: hdl/rpd_top.sv
// Rotor position detector with APB register access
//
// Contract
// - Status bits 5/4 hold the edge result code
// - Edge result encodes current, off, preceding pulse
// - Status bit 3 shows sampling in progress
// - Change mode latches start inputs W,V,U
// - Bits 7:6 pick sample clock div 4..32
// - Bits 5:4 pick PWM-on, continuous, lower-phase
// - Ordinary mode fires after N consecutive matches
// - Change mode fires after N consecutive mismatches
// - Soft stop ends sampling, qualified match still fires
// - Soft start begins sampling at once
// - Timer stop trigger ends sampling when enabled
// - Timer start trigger begins sampling when enabled
// - Single input mode compares U only
// - Inputs configured as outputs compare as zero
// - Recount clears match counter while PWM off, in PWM-on mode only
// - Without recount the counter spans PWM intervals
// - Ordinary mode fires on mismatch turning match
// - Change mode fires on change from start
// - Control bit 0 enables detection; starts need it, clearing it ends sampling
// - Mode codes 00 PWM, 01 continuous, 10 lower
// - Count values 0 and 1 need one sample
// - Ordinary mode compares against expected pattern input
//
// Chosen here: the APB interface to the registers.
`include "rpd_defines.svh"

module rpd_top
    import rpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pos_in_u,
    input wire logic pos_in_v,
    input wire logic pos_in_w,
    input wire logic [2:0] pos_pin_is_output,
    input wire logic [2:0] expected_pattern_reg,
    input wire logic pwm_active,
    input wire logic lower_phase_on,
    input wire logic timer_start_trig,
    input wire logic timer_stop_trig,
    output logic detect_pulse,
    output logic detect_irq
);

    rpd_state_vec_type state_r;
    rpd_state_vec_type state_nxt;

    // Needed qualifying samples; 0 and 1 both mean one
    function automatic logic [3:0] rpd_needed(input logic [3:0] cnt);
        rpd_needed = (cnt == `RPD_COUNT_ZERO) ? `RPD_COUNT_ONE : cnt;
    endfunction

    // Compare pattern, U only when single input selected
    function automatic logic rpd_equal(input logic [2:0] a, input logic [2:0] b, input logic single);
        rpd_equal = single ? (a[0] == b[0]) : (a == b);
    endfunction

    // Count after a qualifying sample; the needed count never exceeds 15
    function automatic logic [3:0] rpd_count_up(input logic [3:0] cnt);
        rpd_count_up = cnt + `RPD_COUNT_ONE;
    endfunction

    // Whether one more qualifying sample completes the run
    function automatic logic rpd_reached(input logic [3:0] cnt, input logic [3:0] needed_cfg);
        rpd_reached = rpd_count_up(cnt) >= rpd_needed(needed_cfg);
    endfunction

    // Address decode of one register word
    function automatic logic rpd_addr_is(input logic [15:0] addr, input logic [15:0] word_addr);
        rpd_addr_is = (addr == word_addr);
    endfunction

    // Sampling mode field of the config byte
    function automatic rpd_mode_type rpd_mode_of(input logic [7:0] cfg);
        rpd_mode_of = rpd_mode_type'(cfg[`RPD_CFG_MODE_HI:`RPD_CFG_MODE_LO]);
    endfunction

    // A sample falls where the masked divider bits are all ones
    function automatic logic rpd_tick(input logic [4:0] cnt, input logic [4:0] mask);
        rpd_tick = ((cnt & mask) == mask);
    endfunction

    // Low-bit mask of the free divider
    function automatic logic [4:0] rpd_div_mask(input logic [1:0] sel);
        case (sel)
            2'h0: begin
                rpd_div_mask = `RPD_DIV_MASK_4;
            end
            2'h1: begin
                rpd_div_mask = `RPD_DIV_MASK_8;
            end
            2'h2: begin
                rpd_div_mask = `RPD_DIV_MASK_16;
            end
            default: begin
                rpd_div_mask = `RPD_DIV_MASK_32;
            end
        endcase
    endfunction

    // Whether the selected mode lets a tick be sampled
    function automatic logic rpd_gate(input rpd_mode_type sel, input logic pwm, input logic lower);
        case (sel)
            RPD_MODE_PWM_ON: begin
                rpd_gate = pwm;
            end
            RPD_MODE_CONTINUOUS: begin
                rpd_gate = 1'b1;
            end
            RPD_MODE_LOWER_PHASE: begin
                rpd_gate = lower;
            end
            default: begin
                // Reserved code samples nothing
                rpd_gate = 1'b0;
            end
        endcase
    endfunction

    // Where in the PWM pulse the detection fell
    function automatic logic [1:0] rpd_edge_code(input logic pwm, input logic rose);
        if (!pwm) begin
            rpd_edge_code = `RPD_EDGE_PWM_OFF;
        end else if (rose) begin
            rpd_edge_code = `RPD_EDGE_CURRENT;
        end else begin
            // On since before the start: pulse began earlier
            rpd_edge_code = `RPD_EDGE_PRECEDING;
        end
    endfunction

    // Status byte: edge result, sampling flag, start pattern
    function automatic logic [31:0] rpd_status_word(input logic [1:0] edge_code, input logic busy,
        input logic [2:0] pattern);
        rpd_status_word = {24'h000000, 2'h0, edge_code, busy, pattern};
    endfunction

    // Read mux; strobes are never stored so they read zero
    function automatic logic [31:0] rpd_read_word(input logic [15:0] addr, input logic [7:0] control,
        input logic [7:0] config_reg, input logic [31:0] status);
        case (addr)
            `RPD_ADDR_CONTROL: begin
                rpd_read_word = {24'h000000, control & `RPD_CTL_STORED_MASK};
            end
            `RPD_ADDR_CONFIG: begin
                rpd_read_word = {24'h000000, config_reg};
            end
            `RPD_ADDR_STATUS: begin
                rpd_read_word = status;
            end
            default: begin
                rpd_read_word = 32'h00000000;
            end
        endcase
    endfunction

    // Reference pattern: start pattern in change mode, else expected input
    function automatic logic [2:0] rpd_reference(input logic change, input logic [2:0] start,
        input logic [2:0] expected);
        if (change) begin
            rpd_reference = start;
        end else begin
            rpd_reference = expected;
        end
    endfunction

    // Ordinary mode needs a mismatch seen before matches count
    function automatic logic rpd_qualify(input logic change, input logic same, input logic seen_diff);
        if (change) begin
            rpd_qualify = ~same;
        end else begin
            rpd_qualify = same & seen_diff;
        end
    endfunction

    logic [2:0] pos_now;
    logic [4:0] div_mask;
    logic sample_tick;
    logic gate_open;
    logic same;
    logic qualify;
    logic start_req;
    logic stop_req;
    logic bus_done;
    logic wr_ctl;
    logic wr_cfg;
    logic mapped;
    rpd_mode_type mode;
    logic [31:0] rd_word;
    logic sample_now;
    logic recount_clear;
    logic soft_start_hit;
    logic timer_start_hit;
    logic soft_stop_hit;
    logic timer_stop_hit;
    logic [2:0] ref_pat;
    logic [3:0] count_cfg;

    always_comb begin
        state_nxt = state_r;
        // Pins set as outputs read as zero, allowing masking
        pos_now = {pos_in_w, pos_in_v, pos_in_u} & ~pos_pin_is_output;
        mode = rpd_mode_of(state_r.config_reg);

        // APB: completes one cycle into the access phase
        bus_done = psel & penable & state_r.pready;
        mapped = rpd_addr_is(paddr, `RPD_ADDR_CONTROL) | rpd_addr_is(paddr, `RPD_ADDR_CONFIG) |
            rpd_addr_is(paddr, `RPD_ADDR_STATUS);
        wr_ctl = bus_done & pwrite & rpd_addr_is(paddr, `RPD_ADDR_CONTROL);
        wr_cfg = bus_done & pwrite & rpd_addr_is(paddr, `RPD_ADDR_CONFIG);

        rd_word = rpd_read_word(paddr, state_r.control, state_r.config_reg,
            rpd_status_word(state_r.edge_result, state_r.state == RPD_ST_SAMPLING, state_r.start_pattern));

        // First access cycle is answered in the next; no other wait states
        if (psel && penable && !state_r.pready) begin
            state_nxt.pready = 1'b1;
            state_nxt.pslverr = ~mapped;
            if (pwrite) begin
                state_nxt.prdata = 32'h00000000;
            end else begin
                state_nxt.prdata = rd_word;
            end
        end else begin
            state_nxt.pready = 1'b0;
            state_nxt.pslverr = 1'b0;
            state_nxt.prdata = 32'h00000000;
        end

        if (wr_ctl) begin
            // Strobes are acted on below and never stored
            state_nxt.control = pwdata[7:0] & `RPD_CTL_STORED_MASK;
        end
        if (wr_cfg) begin
            // Settings are expected to change only while disabled
            state_nxt.config_reg = pwdata[7:0];
        end

        // Sample clock divider
        div_mask = rpd_div_mask(state_r.config_reg[`RPD_CFG_CLK_HI:`RPD_CFG_CLK_LO]);
        sample_tick = rpd_tick(state_r.div_count, div_mask);
        state_nxt.div_count = state_r.div_count + 5'h01;

        gate_open = rpd_gate(mode, pwm_active, lower_phase_on);
        sample_now = sample_tick & gate_open;
        count_cfg = state_r.config_reg[`RPD_CFG_COUNT_HI:`RPD_CFG_COUNT_LO];
        // Recount: counter restarts each PWM-on interval
        recount_clear = (mode == RPD_MODE_PWM_ON) & state_r.control[`RPD_CTL_RECOUNT_EN] & ~pwm_active;

        soft_start_hit = wr_ctl & pwdata[`RPD_CTL_SOFT_START];
        timer_start_hit = state_r.control[`RPD_CTL_TIMER_START_EN] & timer_start_trig;
        soft_stop_hit = wr_ctl & pwdata[`RPD_CTL_SOFT_STOP];
        timer_stop_hit = state_r.control[`RPD_CTL_TIMER_STOP_EN] & timer_stop_trig;
        // Start only when already enabled; a stop needs no detect enable
        start_req = state_r.control[`RPD_CTL_DETECT_EN] & (soft_start_hit | timer_start_hit);
        stop_req = soft_stop_hit | timer_stop_hit;

        ref_pat = rpd_reference(state_r.control[`RPD_CTL_CHANGE_DETECT], state_r.start_pattern,
            expected_pattern_reg);
        same = rpd_equal(pos_now, ref_pat, state_r.control[`RPD_CTL_SINGLE_INPUT]);
        qualify = rpd_qualify(state_r.control[`RPD_CTL_CHANGE_DETECT], same, state_r.seen_diff);

        state_nxt.pwm_prev = pwm_active;
        state_nxt.detect_pulse = 1'b0;
        state_nxt.detect_irq = 1'b0;

        case (state_r.state)
            RPD_ST_IDLE: begin
                if (start_req) begin
                    state_nxt.state = RPD_ST_SAMPLING;
                    state_nxt.start_pattern = pos_now;
                    state_nxt.hit_count = `RPD_COUNT_ZERO;
                    state_nxt.seen_diff = 1'b0;
                    state_nxt.rose_since_start = 1'b0;
                    state_nxt.edge_result = `RPD_EDGE_CURRENT;
                end
            end
            RPD_ST_SAMPLING, RPD_ST_DETECTED: begin
                if (pwm_active & ~state_r.pwm_prev) begin
                    state_nxt.rose_since_start = 1'b1;
                end
                if (recount_clear) begin
                    state_nxt.hit_count = `RPD_COUNT_ZERO;
                end else if (sample_now) begin
                    // Counter otherwise spans PWM intervals
                    if (qualify) begin
                        state_nxt.hit_count = rpd_count_up(state_r.hit_count);
                    end else begin
                        state_nxt.hit_count = `RPD_COUNT_ZERO;
                    end
                    if (!same) begin
                        state_nxt.seen_diff = 1'b1;
                    end
                    if (qualify && rpd_reached(state_r.hit_count, count_cfg)) begin
                        state_nxt.state = RPD_ST_DETECTED;
                    end
                end
                if (state_r.state == RPD_ST_DETECTED) begin
                    // A qualified match fires even if a stop coincides
                    state_nxt.detect_pulse = 1'b1;
                    state_nxt.detect_irq = 1'b1;
                    state_nxt.state = RPD_ST_IDLE;
                    state_nxt.hit_count = `RPD_COUNT_ZERO;
                    state_nxt.edge_result = rpd_edge_code(pwm_active, state_r.rose_since_start);
                end else if (stop_req && state_nxt.state != RPD_ST_DETECTED) begin
                    state_nxt.state = RPD_ST_IDLE;
                end
            end
            default: begin
                state_nxt.state = RPD_ST_IDLE;
            end
        endcase

        if (!state_r.control[`RPD_CTL_DETECT_EN] && state_r.state == RPD_ST_SAMPLING) begin
            state_nxt.state = RPD_ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= '0;
            state_r.control <= `RPD_RESET_CONTROL;
            state_r.config_reg <= `RPD_RESET_CONFIG;
            state_r.state <= RPD_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata = state_r.prdata;
    assign pready = state_r.pready;
    assign pslverr = state_r.pslverr;
    assign detect_pulse = state_r.detect_pulse;
    assign detect_irq = state_r.detect_irq;

endmodule // rpd_top

// File: hdl/rpd_defines.svh
// Register map, field positions and reset values of the rotor position detector
`ifndef RPD_DEFINES_SVH
`define RPD_DEFINES_SVH

`define RPD_IDX_CONTROL 16'h1FA0
`define RPD_IDX_CONFIG 16'h1FA1
`define RPD_IDX_STATUS 16'h1FA2
`define RPD_ADDR_CONTROL 16'h7E80
`define RPD_ADDR_CONFIG 16'h7E84
`define RPD_ADDR_STATUS 16'h7E88

`define RPD_CTL_SOFT_STOP 7
`define RPD_CTL_SOFT_START 6
`define RPD_CTL_TIMER_STOP_EN 5
`define RPD_CTL_TIMER_START_EN 4
`define RPD_CTL_SINGLE_INPUT 3
`define RPD_CTL_RECOUNT_EN 2
`define RPD_CTL_CHANGE_DETECT 1
`define RPD_CTL_DETECT_EN 0
`define RPD_CTL_STORED_MASK 8'h3F

`define RPD_CFG_CLK_HI 7
`define RPD_CFG_CLK_LO 6
`define RPD_CFG_MODE_HI 5
`define RPD_CFG_MODE_LO 4
`define RPD_CFG_COUNT_HI 3
`define RPD_CFG_COUNT_LO 0

`define RPD_RESET_CONTROL 8'h00
`define RPD_RESET_CONFIG 8'h00
`define RPD_RESET_STATUS 8'h00

`define RPD_EDGE_CURRENT 2'h0
`define RPD_EDGE_PWM_OFF 2'h1
`define RPD_EDGE_PRECEDING 2'h3

`define RPD_DIV_MASK_4 5'h03
`define RPD_DIV_MASK_8 5'h07
`define RPD_DIV_MASK_16 5'h0F
`define RPD_DIV_MASK_32 5'h1F

`define RPD_COUNT_ZERO 4'h0
`define RPD_COUNT_ONE 4'h1

`endif

// File: hdl/rpd_pkg.sv
// Types shared by the rotor position detector
package rpd_pkg;

    typedef enum logic [1:0] {
        RPD_MODE_PWM_ON = 2'h0,
        RPD_MODE_CONTINUOUS = 2'h1,
        RPD_MODE_LOWER_PHASE = 2'h2,
        RPD_MODE_RESERVED = 2'h3
    } rpd_mode_type;

    typedef enum logic [1:0] {
        RPD_ST_IDLE = 2'h0,
        RPD_ST_SAMPLING = 2'h1,
        RPD_ST_DETECTED = 2'h3
    } rpd_state_type;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] config_reg;
        rpd_state_type state;
        logic [2:0] start_pattern;
        logic [1:0] edge_result;
        logic [3:0] hit_count;
        logic [4:0] div_count;
        logic seen_diff;
        logic rose_since_start;
        logic pwm_prev;
        logic detect_pulse;
        logic detect_irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rpd_state_vec_type;

endpackage : rpd_pkg

// File: dv/rpd_sensor_model.sv
// Behavioural position sensors facing the detector
module rpd_sensor_model (
    input wire logic clk_sys,
    input wire logic [2:0] want,
    output logic pos_in_u = 1'b0,
    output logic pos_in_v = 1'b0,
    output logic pos_in_w = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Registered so a new pattern lands just after an edge, like a synchronised comparator
    always @(posedge clk_sys) begin
        {pos_in_w, pos_in_v, pos_in_u} <= want;
    end
endmodule // rpd_sensor_model

// File: dv/rpd_top_properties.sv
// Port checker for the rotor position detector
`include "rpd_defines.svh"
module rpd_top_properties (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic detect_pulse,
    input wire logic detect_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic rd_done = psel && penable && pready && !pwrite;
    sequence setup_s; psel && !penable; endsequence
    sequence wait_s; psel && penable && !pready; endsequence
    AST_APB_ANSWER: assert property (setup_s |=> wait_s ##1 pready)
        else $error("access not answered on second access cycle");
    AST_PULSE_PAIR: assert property (detect_pulse == detect_irq)
        else $error("detect pulse and interrupt apart");
    AST_PULSE_SINGLE: assert property (detect_pulse |=> !detect_pulse [*2])
        else $error("detection repeated after sampling ended");
    AST_STROBE_ZERO: assert property (rd_done && paddr == `RPD_ADDR_CONTROL |-> prdata[7:6] == 2'h0)
        else $error("start or stop strobe read back set");
    AST_STATUS_TOP: assert property (rd_done && paddr == `RPD_ADDR_STATUS |-> prdata[31:6] == 26'h0)
        else $error("status upper bits set");
    AST_EDGE_CODE: assert property (rd_done && paddr == `RPD_ADDR_STATUS |-> prdata[5:4] != 2'h2)
        else $error("edge result code 10 seen");
    AST_CONFIG_WIDTH: assert property (rd_done && paddr == `RPD_ADDR_CONFIG |-> prdata[31:8] == 24'h0)
        else $error("config upper bits set");
    AST_ERR_READY: assert property (pslverr |-> pready && !$past(pready))
        else $error("error response outside answer cycle");
endmodule // rpd_top_properties

// File: dv/rpd_top_test.sv
// Self-checking bench for the rotor position detector
`include "rpd_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("Error %0t: %h != %h", $time, a, b); end end
module rpd_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, detect_pulse, detect_irq;
    logic pwm_active = 1, lower_phase_on = 0, t_start = 0, t_stop = 0, pu, pv, pw;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] mask = 3'h0, exp_pat = 3'h0, want = 3'h0;
    int errors = 0, check_count = 0, seed = 92229;
    rpd_sensor_model sns_u (.clk_sys(clk_sys), .want(want), .pos_in_u(pu), .pos_in_v(pv), .pos_in_w(pw));
    rpd_top dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_in_u(pu), .pos_in_v(pv),
        .pos_in_w(pw), .pos_pin_is_output(mask), .expected_pattern_reg(exp_pat), .pwm_active(pwm_active),
        .lower_phase_on(lower_phase_on), .timer_start_trig(t_start), .timer_stop_trig(t_stop),
        .detect_pulse(detect_pulse), .detect_irq(detect_irq));
    initial forever #4 clk_sys = ~clk_sys;
    function automatic int need(logic [7:0] c);
        return (c[3:0] < 2) ? 1 : int'(c[3:0]);
    endfunction
    task automatic results();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [31:0] q,
                       output logic e);
        int k = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1;
        // Access ends at the rising edge that samples pready high; data taken there
        do begin @(posedge clk_sys); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin errors++; results(); end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic run(input logic [7:0] ctl, input logic [7:0] cfg, input logic [2:0] p0, input logic [2:0] p1,
                       input logic hit, input logic tmr, input int stp);
        logic [31:0] q;
        logic e;
        int k = 0;
        int dv = 4 << cfg[7:6];
        want <= p0;
        apb(1, `RPD_ADDR_CONTROL, 8'h00, q, e);
        apb(1, `RPD_ADDR_CONFIG, cfg, q, e);
        apb(1, `RPD_ADDR_CONTROL, ctl, q, e);
        if (tmr) begin t_start <= 1; @(posedge clk_sys); t_start <= 0; end
        else apb(1, `RPD_ADDR_CONTROL, ctl | 8'h40, q, e);
        apb(0, `RPD_ADDR_STATUS, 8'h00, q, e);
        `CHK(q[3], 1'b1)
        if (ctl[1]) `CHK(q[2:0], p0 & ~mask)
        if (stp == 1) apb(1, `RPD_ADDR_CONTROL, ctl | 8'h80, q, e);
        if (stp == 2) begin t_stop <= 1; @(posedge clk_sys); t_stop <= 0; end
        repeat (2 * dv) @(posedge clk_sys);
        want <= p1;
        do begin @(negedge clk_sys); k++; end while (detect_pulse !== 1'b1 && k < need(cfg) * dv + 20);
        `CHK(detect_pulse, hit)
        `CHK(detect_irq, hit)
        if (hit) `CHK(k >= (need(cfg) - 1) * dv && k <= need(cfg) * dv + 8, 1'b1)
        @(posedge clk_sys);
        apb(0, `RPD_ADDR_STATUS, 8'h00, q, e);
        `CHK(q[3], !hit && stp == 0)
        if (hit) `CHK(q[5:4], pwm_active ? `RPD_EDGE_PRECEDING : `RPD_EDGE_PWM_OFF)
        $display("Run done ctl %h cfg %h", ctl, cfg);
    endtask
    initial begin
        logic [31:0] q;
        logic e;
        logic [7:0] ctl, cfg;
        logic [2:0] ex, p0;
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            apb(0, 16'h7E80 + 16'(4 * i), 8'h00, q, e);
            `CHK({e, q}, {i == 3, 32'h0})
        end
        apb(1, `RPD_ADDR_CONTROL, 8'hFE, q, e);
        apb(0, `RPD_ADDR_CONTROL, 8'h00, q, e);
        `CHK(q, 32'h3E)
        for (int i = 0; i < 8; i++) begin
            cfg = {2'($random(seed)), 2'h1, 4'($random(seed))};
            ctl = {3'h0, i[0], 1'($random(seed)), 1'b0, 1'($random(seed)), 1'b1};
            ex = 3'($random(seed));
            p0 = 3'($random(seed));
            exp_pat <= ex;
            pwm_active <= 1'($random(seed));
            if (ctl[1]) run(ctl, cfg, p0, p0 ^ 3'h1, 1, i[0], 0);
            else run(ctl, cfg, ~ex, ctl[3] ? {p0[2:1], ex[0]} : ex, 1, i[0], 0);
        end
        mask <= 3'h6;
        exp_pat <= 3'h1;
        run(8'h01, 8'h11, 3'h0, 3'h7, 1, 0, 0);
        mask <= 3'h0;
        run(8'h01, 8'h14, 3'h0, 3'h1, 0, 0, 1);
        run(8'h21, 8'h14, 3'h0, 3'h1, 0, 0, 2);
        pwm_active <= 0;
        run(8'h01, 8'h02, 3'h0, 3'h1, 0, 0, 0);
        pwm_active <= 1;
        run(8'h05, 8'h43, 3'h0, 3'h1, 1, 0, 0);
        lower_phase_on <= 1;
        run(8'h01, 8'h21, 3'h0, 3'h1, 1, 0, 0);
        run(8'h01, 8'h31, 3'h0, 3'h1, 0, 0, 0);
        results();
    end
endmodule // rpd_top_test
bind rpd_top rpd_top_properties chk_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .detect_pulse, .detect_irq);
